// file: rtl/sss_top.sv
// step and direction sequencer with phase current targets and apb status
// Summary of operation
// [R01] rising step edge advances index, updates targets
// [R02] falling step edge changes nothing
// [R03] enable high drives bridges, regulates current
// [R04] enable low turns bridges off, high impedance
// [R05] direction high forward, low reverse
// [R06] select 000 gives full step
// [R07] select 001 gives half step (a)
// [R08] select 010 gives half step (b)
// [R09] select 011 gives quarter step
// [R10] select 100 gives eighth step
// [R11] select 101 gives sixteenth step
// [R12] select bits 0,1 high give thirty-second step
// [R13] fine mode follows cosine/sine percent table
// [R14] coarser modes use subsets of table
// [R15] half (a) and full use 100 diagonals
// [R16] sleep low stops pump and regulator
// [R17] index wraps modulo 128, up or down
// [R18] start index after reset or sleep exit
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module sss_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic step,
  input wire logic rotation_direction,
  input wire logic output_enable,
  input wire logic sleep_n,
  input wire logic resolution_select_0,
  input wire logic resolution_select_1,
  input wire logic resolution_select_2,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [sss_pkg::IDX_W-1:0] angle_index,
  output logic signed [sss_pkg::PCT_W-1:0] phase_a_target,
  output logic signed [sss_pkg::PCT_W-1:0] phase_b_target,
  output logic bridge_on,
  output logic output_hiz,
  output logic charge_pump_on,
  output logic regulator_on
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // resolution select pins to mode
  function automatic sss_pkg::sss_mode_t decode_mode(input logic [2:0] sel);
    unique case (sel)
      3'b000: decode_mode = sss_pkg::SSS_FULL; // R06
      3'b100: decode_mode = sss_pkg::SSS_HALF_A; // R07
      3'b010: decode_mode = sss_pkg::SSS_HALF_B; // R08
      3'b110: decode_mode = sss_pkg::SSS_QUARTER; // R09
      3'b001: decode_mode = sss_pkg::SSS_EIGHTH; // R10
      3'b101: decode_mode = sss_pkg::SSS_SIXTEENTH; // R11
      default: decode_mode = sss_pkg::SSS_THIRTYSECOND; // R12
    endcase
  endfunction : decode_mode

  // index distance of one step; coarse modes walk a subset of the table
  function automatic logic [sss_pkg::IDX_W-1:0] step_size(input sss_pkg::sss_mode_t m);
    unique case (m) // R14
      sss_pkg::SSS_FULL: step_size = 7'h20;
      sss_pkg::SSS_HALF_A, sss_pkg::SSS_HALF_B: step_size = 7'h10;
      sss_pkg::SSS_QUARTER: step_size = 7'h08;
      sss_pkg::SSS_EIGHTH: step_size = 7'h04;
      sss_pkg::SSS_SIXTEENTH: step_size = 7'h02;
      sss_pkg::SSS_THIRTYSECOND: step_size = 7'h01;
    endcase
  endfunction : step_size

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [sss_pkg::SYNC_W-1:0] pins_s; // synchronised pins
  logic step_s, dir_s, en_s, awake_s; // named views of the pins
  logic [2:0] sel_s; // bit i = resolution_select_i

  sss_sync #(.W(sss_pkg::SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({resolution_select_2, resolution_select_1, resolution_select_0, sleep_n, output_enable,
               rotation_direction, step}),
    .sync_out(pins_s)
  );

  assign step_s = pins_s[0];
  assign dir_s = pins_s[1];
  assign en_s = pins_s[2];
  assign awake_s = pins_s[3];
  assign sel_s = {pins_s[6], pins_s[5], pins_s[4]};

  // ----------------------------------------------------------------
  // edge detect and mode
  // ----------------------------------------------------------------
  logic step_d_reg; // previous synchronised step level
  sss_pkg::sss_mode_t mode_reg; // decoded resolution
  logic step_rise; // rising step edge only

  // delayed step level; a falling edge yields nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_d_reg <= 1'b0;
    end else begin
      step_d_reg <= step_s;
    end
  end

  assign step_rise = step_s & ~step_d_reg; // R01 R02

  // mode follows the pins every cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= sss_pkg::SSS_FULL;
    end else begin
      mode_reg <= decode_mode(sel_s);
    end
  end

  // ----------------------------------------------------------------
  // angle index
  // ----------------------------------------------------------------
  logic home_pend_reg; // start position still to be loaded
  logic home_req; // software asks for start position
  logic load_home; // start position loaded this cycle
  logic run; // steps accepted this cycle
  logic [sss_pkg::IDX_W-1:0] index_next;

  assign load_home = home_pend_reg & awake_s;
  assign run = step_rise & en_s & awake_s & ~home_pend_reg; // disabled or asleep ignores steps

  // pending flag: set by reset, sleep and software, cleared once loaded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      home_pend_reg <= 1'b1; // R18
    end else if (!awake_s || home_req) begin
      home_pend_reg <= 1'b1; // R18
    end else if (load_home) begin
      home_pend_reg <= 1'b0;
    end
  end

  // next index; wraps naturally in seven bits
  // start index decodes the pins directly: mode_reg still lags them on the first load after reset
  always_comb begin
    if (load_home) begin
      index_next = (decode_mode(sel_s) == sss_pkg::SSS_FULL) ? sss_pkg::INIT_FULL : sss_pkg::INIT_FINE; // R18
    end else if (run && dir_s) begin
      index_next = angle_index + step_size(mode_reg); // R01 R05 R17
    end else if (run) begin
      index_next = angle_index - step_size(mode_reg); // R05 R17
    end else begin
      index_next = angle_index; // R02
    end
  end

  // index register is an output straight from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      angle_index <= sss_pkg::INIT_FINE;
    end else begin
      angle_index <= index_next;
    end
  end

  // ----------------------------------------------------------------
  // current targets, one cycle after the index
  // ----------------------------------------------------------------
  logic signed [sss_pkg::PCT_W-1:0] tab_a, tab_b;

  sss_phase_table u_table (
    .angle_index(angle_index),
    .mode(mode_reg),
    .phase_a(tab_a),
    .phase_b(tab_b)
  );

  // registered targets keep the outputs glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_a_target <= sss_pkg::PCT_FULL;
      phase_b_target <= '0;
    end else begin
      phase_a_target <= tab_a; // R01 R13 R14
      phase_b_target <= tab_b; // R01 R13 R14
    end
  end

  // ----------------------------------------------------------------
  // bridge and supply control
  // ----------------------------------------------------------------
  // reset leaves every transistor off until the pins are seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bridge_on <= 1'b0;
      output_hiz <= 1'b1;
      charge_pump_on <= 1'b0;
      regulator_on <= 1'b0;
    end else begin
      bridge_on <= en_s & awake_s; // R03
      output_hiz <= ~(en_s & awake_s); // R04
      charge_pump_on <= awake_s; // R16
      regulator_on <= awake_s; // R16
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait, one access cycle
  // ----------------------------------------------------------------
  logic apb_setup; // setup phase seen
  logic apb_wr; // write completes this edge
  logic map_hit; // address is mapped

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pready & pwrite;
  assign map_hit = paddr == sss_pkg::OFS_CTRL || paddr == sss_pkg::OFS_STATUS || paddr == sss_pkg::OFS_TARGET;
  assign home_req = apb_wr && paddr == sss_pkg::OFS_CTRL && pwdata[sss_pkg::CTRL_HOME_BIT];

  // answer prepared in the setup cycle, shown in the access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~map_hit;
      prdata <= '0;
      if (apb_setup && !pwrite && paddr == sss_pkg::OFS_STATUS) begin
        prdata[sss_pkg::IDX_W-1:0] <= angle_index;
        prdata[sss_pkg::ST_MODE_LSB +: 3] <= mode_reg;
        prdata[sss_pkg::ST_EN_BIT] <= en_s;
        prdata[sss_pkg::ST_AWAKE_BIT] <= awake_s;
      end else if (apb_setup && !pwrite && paddr == sss_pkg::OFS_TARGET) begin
        prdata[sss_pkg::PCT_W-1:0] <= phase_a_target;
        prdata[sss_pkg::TG_B_LSB +: sss_pkg::PCT_W] <= phase_b_target;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_rise_forward: assert property (run && dir_s |=> angle_index == $past(angle_index) + $past(step_size(mode_reg))) // R01
    else $error("forward step did not advance index");
  a_rise_reverse: assert property (run && !dir_s |=> angle_index == $past(angle_index) - $past(step_size(mode_reg))) // R17
    else $error("reverse step did not retreat index");
  a_fall_hold: assert property (!step_rise && !load_home |=> $stable(angle_index)) // R02
    else $error("index moved without rising step");
  a_dir_sense: assert property (run && !home_pend_reg && step_size(mode_reg) == 7'h01 && dir_s |=> angle_index != $past(angle_index) - 7'h01) // R05
    else $error("direction sense reversed");
  a_enable_drive: assert property (en_s && awake_s |=> bridge_on && !output_hiz) // R03
    else $error("bridge not driven while enabled");
  a_disable_hiz: assert property (!en_s |=> !bridge_on && output_hiz) // R04
    else $error("bridge driven while disabled");
  a_sleep_pump: assert property (!awake_s |=> !charge_pump_on && !regulator_on) // R16
    else $error("pump or regulator on in sleep");
  a_mode_full: assert property (sel_s == 3'b000 |=> mode_reg == sss_pkg::SSS_FULL) // R06
    else $error("full mode not decoded");
  a_mode_half_a: assert property (sel_s == 3'b100 |=> mode_reg == sss_pkg::SSS_HALF_A) // R07
    else $error("half a not decoded");
  a_mode_half_b: assert property (sel_s == 3'b010 |=> mode_reg == sss_pkg::SSS_HALF_B) // R08
    else $error("half b not decoded");
  a_mode_quarter: assert property (sel_s == 3'b110 |=> mode_reg == sss_pkg::SSS_QUARTER) // R09
    else $error("quarter not decoded");
  a_mode_eighth: assert property (sel_s == 3'b001 |=> mode_reg == sss_pkg::SSS_EIGHTH) // R10
    else $error("eighth not decoded");
  a_mode_sixteenth: assert property (sel_s == 3'b101 |=> mode_reg == sss_pkg::SSS_SIXTEENTH) // R11
    else $error("sixteenth not decoded");
  a_mode_fine: assert property (sel_s[0] && sel_s[1] |=> mode_reg == sss_pkg::SSS_THIRTYSECOND) // R12
    else $error("thirty-second not decoded");
  a_table_one: assert property (angle_index == 7'h01 && mode_reg == sss_pkg::SSS_THIRTYSECOND
    |=> phase_a_target == sss_pkg::PCT_FULL && phase_b_target == 8'sh05) // R13
    else $error("table entry one wrong");
  a_table_diag: assert property (angle_index == 7'h10 && mode_reg == sss_pkg::SSS_HALF_B
    |=> phase_a_target == 8'sh47 && phase_b_target == 8'sh47) // R14
    else $error("half b diagonal not 71");
  a_full_diag: assert property (angle_index == 7'h30 && mode_reg == sss_pkg::SSS_FULL
    |=> phase_a_target == -sss_pkg::PCT_FULL && phase_b_target == sss_pkg::PCT_FULL) // R15
    else $error("full diagonal not 100");
  a_wake_init: assert property ($rose(awake_s) && !home_req |-> ##[1:2] (angle_index == sss_pkg::INIT_FINE
    || angle_index == sss_pkg::INIT_FULL)) // R18
    else $error("start position not loaded after wake");

  c_forward: cover property (run && dir_s);
  c_reverse: cover property (run && !dir_s);
  c_full_step: cover property (run && mode_reg == sss_pkg::SSS_FULL);
  c_wake: cover property ($rose(awake_s));
endmodule : sss_top

// file: rtl/sss_pkg.sv
// shared constants and types of the stepper step sequencer
package sss_pkg;
  // ----------------------------------------------------------------
  // angle index and current targets
  // ----------------------------------------------------------------
  localparam int IDX_W = 7;                      // 128 electrical positions
  localparam int PCT_W = 8;                      // signed percent target
  localparam int QTR_W = 5;                      // index bits inside one quadrant
  localparam logic [4:0] DIAG_K = 5'h10;         // diagonal position in a quadrant
  localparam logic [5:0] QTR_SPAN = 6'h20;       // positions per quadrant
  localparam logic signed [7:0] PCT_FULL = 8'sh64; // 100 percent
  localparam logic [6:0] INIT_FINE = 7'h00;      // start index, fine modes
  localparam logic [6:0] INIT_FULL = 7'h10;      // start index, full step
  localparam int SYNC_W = 7;                     // pins through the synchroniser

  // ----------------------------------------------------------------
  // step resolution
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSS_FULL, SSS_HALF_A, SSS_HALF_B, SSS_QUARTER, SSS_EIGHTH, SSS_SIXTEENTH, SSS_THIRTYSECOND
  } sss_mode_t;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;       // bit0 write 1 = return to start position
  localparam logic [7:0] OFS_STATUS = 8'h04;     // index, mode, enable, awake
  localparam logic [7:0] OFS_TARGET = 8'h08;     // phase a and b targets
  localparam int CTRL_HOME_BIT = 0;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_EN_BIT = 12;
  localparam int ST_AWAKE_BIT = 13;
  localparam int TG_B_LSB = 8;
endpackage : sss_pkg

// file: rtl/sss_sync.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module sss_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // ----------------------------------------------------------------
  // two stages; the first stage feeds only the second
  // ----------------------------------------------------------------
  logic [W-1:0] meta_reg; // may go metastable, never read by logic

  // both stages clear on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sss_sync

// file: rtl/sss_phase_table.sv
// cosine/sine lookup from angle index to phase current targets
`timescale 1ns/1ps
module sss_phase_table (
  input wire logic [sss_pkg::IDX_W-1:0] angle_index,
  input wire sss_pkg::sss_mode_t mode,
  output logic signed [sss_pkg::PCT_W-1:0] phase_a,
  output logic signed [sss_pkg::PCT_W-1:0] phase_b
);
  // ----------------------------------------------------------------
  // first quadrant of the sine in percent, positions 0..32
  // ----------------------------------------------------------------
  localparam logic [6:0] SINE [0:32] = '{
    7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h18, 7'h1D, 7'h22, 7'h26, 7'h2B, 7'h2F,
    7'h33, 7'h38, 7'h3C, 7'h3F, 7'h43, 7'h47, 7'h4A, 7'h4D, 7'h50, 7'h53, 7'h56,
    7'h58, 7'h5A, 7'h5C, 7'h5E, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64, 7'h64
  };

  // ----------------------------------------------------------------
  // quadrant folding and diagonal override
  // ----------------------------------------------------------------
  logic [4:0] k;          // position inside the quadrant
  logic [5:0] kc;         // complementary position
  logic [7:0] mag_s;      // sine magnitude
  logic [7:0] mag_c;      // cosine magnitude
  logic force_full;       // half (a) and full push diagonals to 100

  always_comb begin
    k = angle_index[sss_pkg::QTR_W-1:0];
    kc = sss_pkg::QTR_SPAN - {1'b0, k};
    force_full = (mode == sss_pkg::SSS_HALF_A || mode == sss_pkg::SSS_FULL) && k == sss_pkg::DIAG_K; // R15
    mag_s = force_full ? sss_pkg::PCT_FULL : {1'b0, SINE[k]}; // R13
    mag_c = force_full ? sss_pkg::PCT_FULL : {1'b0, SINE[kc]}; // R13
    // sign per quadrant, counting counter-clockwise from phase a positive
    unique case (angle_index[sss_pkg::IDX_W-1:sss_pkg::QTR_W]) // R17
      2'b00: begin
        phase_a = $signed(mag_c);
        phase_b = $signed(mag_s);
      end
      2'b01: begin
        phase_a = -$signed(mag_s);
        phase_b = $signed(mag_c);
      end
      2'b10: begin
        phase_a = -$signed(mag_c);
        phase_b = -$signed(mag_s);
      end
      2'b11: begin
        phase_a = $signed(mag_s);
        phase_b = -$signed(mag_c);
      end
    endcase
  end
endmodule : sss_phase_table

// file: sim/sss_ctl_model.sv
// controller model that issues step pulses to the sequencer
`timescale 1ns/1ps
module sss_ctl_model #(
  parameter int HOLD = 3 // clocks per step level; the sync needs two
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] count,
  output logic step,
  output logic busy
);
  logic [7:0] left_reg; // pulses still owed
  logic [3:0] tick_reg; // clocks spent in the present level
  // ----------------------------------------------------------------
  // pulse train: high and low each HOLD clocks so no edge is lost
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_reg <= 8'h00;
      tick_reg <= 4'h0;
      step <= 1'b0;
      busy <= 1'b0;
    end else if (!busy && go && count != 8'h00) begin
      // start a burst; step rises at once
      left_reg <= count;
      tick_reg <= 4'h1;
      step <= 1'b1;
      busy <= 1'b1;
    end else if (busy) begin
      if (tick_reg == 4'(HOLD)) begin
        tick_reg <= 4'h1;
        if (step) begin
          // falling edge ends one pulse
          step <= 1'b0;
          left_reg <= left_reg - 8'h01;
        end else if (left_reg == 8'h00) begin
          busy <= 1'b0;
        end else begin
          step <= 1'b1;
        end
      end else begin
        tick_reg <= tick_reg + 4'h1;
      end
    end
  end
endmodule : sss_ctl_model

// file: sim/tb_stepper_step_sequencer.sv
// self-checking bench of the step sequencer
`timescale 1ns/1ps
module tb_stepper_step_sequencer;
  logic clk, rst, step, dir, en, sleep_n, sel0, sel1, sel2, go, busy;
  logic psel, penable, pwrite, pready, pslverr, bridge_on, output_hiz, pump_on, reg_on;
  logic [7:0] paddr, cnt;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  logic [6:0] angle_index;
  logic signed [7:0] pa, pb;
  int num_errors = 0;
  int cmp_count = 0;
  // per select code {s0,s1,s2}: step size and targets after one step from start
  logic [6:0] st [8] = '{7'h20, 7'h10, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h01};
  logic signed [7:0] ea [8] = '{8'h9C, 8'h64, 8'h47, 8'h5C, 8'h62, 8'h64, 8'h64, 8'h64};
  logic signed [7:0] eb [8] = '{8'h64, 8'h64, 8'h47, 8'h26, 8'h14, 8'h0A, 8'h05, 8'h05};

  // ----------------------------------------------------------------
  // clock, design and controller model
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  sss_top sss_top_inst (.clk(clk), .rst(rst), .step(step), .rotation_direction(dir), .output_enable(en),
    .sleep_n(sleep_n), .resolution_select_0(sel0), .resolution_select_1(sel1), .resolution_select_2(sel2),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .angle_index(angle_index), .phase_a_target(pa), .phase_b_target(pb),
    .bridge_on(bridge_on), .output_hiz(output_hiz), .charge_pump_on(pump_on), .regulator_on(reg_on));
  sss_ctl_model sss_ctl_model_inst (.clk(clk), .rst(rst), .go(go), .count(cnt), .step(step), .busy(busy));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // pins pass a two-flop sync, so give them time to land
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // answer is taken at the very edge that samples pready high, then the request is released
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic do_steps(input logic [7:0] n);
    int w;
    w = 0;
    @(posedge clk);
    go <= 1'b1;
    cnt <= n;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      w++;
    end while (busy === 1'b1 && w < 5000);
    if (w >= 5000) check(32'h0, 32'h1);
    settle();
  endtask : do_steps
  task automatic set_pins(input logic [2:0] c, input logic d);
    @(posedge clk);
    sel0 <= c[2];
    sel1 <= c[1];
    sel2 <= c[0];
    dir <= d;
    settle();
  endtask : set_pins
  task automatic chk_pos(input logic [6:0] idx, input logic signed [7:0] a, input logic signed [7:0] b);
    check({25'h0, angle_index}, {25'h0, idx});
    check(32'(pa), 32'(a));
    check(32'(pb), 32'(b));
  endtask : chk_pos
  task automatic go_home();
    apb(1'b1, sss_pkg::OFS_CTRL, 32'h00000001 << sss_pkg::CTRL_HOME_BIT);
    settle();
  endtask : go_home

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // every select code: start position, one step, status and target words
  task automatic t_modes();
    logic [31:0] exp;
    logic [6:0] ei;
    for (int c = 0; c < 8; c++) begin
      set_pins(3'(c), 1'b1);
      go_home();
      if (c == 0) chk_pos(sss_pkg::INIT_FULL, 8'h64, 8'h64);
      else chk_pos(sss_pkg::INIT_FINE, 8'h64, 8'h00);
      do_steps(8'h01);
      ei = (c == 0 ? sss_pkg::INIT_FULL : sss_pkg::INIT_FINE) + st[c];
      chk_pos(ei, ea[c], eb[c]);
      exp = 32'h0;
      exp[6:0] = ei;
      exp[sss_pkg::ST_MODE_LSB +: 3] = (c == 7) ? 3'h6 : 3'(c);
      exp[sss_pkg::ST_EN_BIT] = 1'b1;
      exp[sss_pkg::ST_AWAKE_BIT] = 1'b1;
      apb(1'b0, sss_pkg::OFS_STATUS, 32'h0);
      check(rd, exp);
      exp = 32'h0;
      exp[7:0] = ea[c];
      exp[sss_pkg::TG_B_LSB +: 8] = eb[c];
      apb(1'b0, sss_pkg::OFS_TARGET, 32'h0);
      check(rd, exp);
    end
    $display("test modes done");
  endtask : t_modes
  // reverse wraps below zero, forward wraps above 127
  task automatic t_direction();
    set_pins(3'h6, 1'b0);
    go_home();
    do_steps(8'h01);
    chk_pos(7'h7F, 8'h64, 8'hFB);
    set_pins(3'h6, 1'b1);
    do_steps(8'h11);
    chk_pos(7'h10, 8'h47, 8'h47);
    $display("test direction done");
  endtask : t_direction
  // disabled bridges float and steps are dropped
  task automatic t_enable();
    @(posedge clk);
    en <= 1'b0;
    settle();
    check({31'h0, bridge_on}, 32'h0);
    check({31'h0, output_hiz}, 32'h1);
    do_steps(8'h02);
    chk_pos(7'h10, 8'h47, 8'h47);
    @(posedge clk);
    en <= 1'b1;
    settle();
    check({30'h0, bridge_on, output_hiz}, 32'h2);
    $display("test enable done");
  endtask : t_enable
  // sleep stops pump and regulator; waking reloads the start index
  task automatic t_sleep();
    do_steps(8'h03);
    chk_pos(7'h13, 8'h3C, 8'h50);
    @(posedge clk);
    sleep_n <= 1'b0;
    settle();
    check({29'h0, pump_on, reg_on, bridge_on}, 32'h0);
    @(posedge clk);
    sleep_n <= 1'b1;
    settle();
    check({30'h0, pump_on, reg_on}, 32'h3);
    chk_pos(7'h00, 8'h64, 8'h00);
    apb(1'b0, 8'h0C, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("test sleep done");
  endtask : t_sleep

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {rst, dir, en, sleep_n, sel0, sel1} = 6'h3F;
    {sel2, go, psel, penable, pwrite} = 5'h00;
    {cnt, paddr, pwdata} = 48'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    check({9'h0, angle_index, pa, pb}, {9'h0, 7'h00, 8'h64, 8'h00});
    check({29'h0, bridge_on, output_hiz, pump_on}, 32'h2);
    @(posedge clk);
    rst <= 1'b0;
    settle();
    check({29'h0, bridge_on, pump_on, reg_on}, 32'h7);
    t_modes();
    t_direction();
    t_enable();
    t_sleep();
    conclude();
  end
  initial begin
    #120000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : tb_stepper_step_sequencer
